// >>> core/stc_params.svh
// Purpose: Constants for the sixteen bit timer counter
// Assumes: Included by its bare name
// Notes: Offsets do not exist; control bits arrive as ports
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH
`define STC_CNT_RST 16'h0000
`define STC_CNT_ALL1 16'hffff
`define STC_SPECIAL_MODE 4'hb
`define STC_FOSC_DIV_LAST 2'h3
`define STC_PS_1 2'h0
`define STC_PS_2 2'h1
`define STC_PS_4 2'h2
`define STC_PS_8 2'h3
`define STC_PS_LAST_1 3'h0
`define STC_PS_LAST_2 3'h1
`define STC_PS_LAST_4 3'h3
`define STC_PS_LAST_8 3'h7
`endif

// >>> core/stc_pkg.sv
// Purpose: Types for the sixteen bit timer counter
// Assumes: Nothing imported by users
// Notes: Control group mirrors the timer control register layout
package stc_pkg;
   // ----------------------------------------
   // Timer control group, bit 7 down to bit 0
   // ----------------------------------------
   typedef struct packed {
      logic wide_access_enable;
      logic spare;
      logic [1:0] prescale_select;
      logic crystal_osc_enable;
      logic ext_clock_sync_bypass;
      logic clock_source_select;
      logic timer_run;
   } stc_ctrl_t;
   // ----------------------------------------
   // Byte access strobes from software
   // ----------------------------------------
   typedef struct packed {
      logic lo_rd;
      logic lo_wr;
      logic hi_rd;
      logic hi_wr;
      logic flag_clr;
      logic [7:0] wdata;
   } stc_acc_t;
endpackage

// >>> core/stc_timer.sv
// Purpose: Sixteen bit up counter with overflow flag and wide access
// Assumes: Software strobes and compare inputs are on clk
// Notes: External clock pin always passes two flops before use
`timescale 1ns/10ps
`include "stc_params.svh"

// How it works
// RQ1: Counter counts up, wraps ffff to zero
// RQ2: Wrap latches overflow flag regardless of enable
// RQ3: Interrupt request only while overflow enable set
// RQ4: Special mode trigger clears counter, starts conversion
// RQ5: Trigger clear never sets overflow flag
// RQ6: Software uses synchronized modes for trigger clears
// RQ7: Write beats simultaneous trigger clear
// RQ8: Compare value pair acts as period
// RQ9: Wide mode maps high address to buffer
// RQ10: Wide low read snapshots high byte
// RQ11: Wide low write loads high from buffer
// RQ12: Wide mode hides live high byte
// RQ13: Only low writes clear the prescaler
// RQ14: Software presets high top bit per overflow
// RQ15: Software runs crystal, async, interrupt enabled
// RQ16: Source select picks instruction or external edges
// RQ17: Prescale codes divide by 1, 2, 4, 8
// RQ18: Run bit starts and stops counting
// RQ19: Sync bit matters only for external source; the code ignores it and always synchronises the pin
// RQ20: Flag stays set until software clears
module stc_timer (
   input wire logic clk,
   input wire logic rstn,
   input wire stc_pkg::stc_ctrl_t ctrl,
   input wire stc_pkg::stc_acc_t acc,
   input wire logic overflow_irq_enable,
   input wire logic [3:0] compare_mode_select,
   input wire logic [15:0] compare_value_pair,
   input wire logic adc_enable,
   input wire logic ext_clk_pin,
   output logic [7:0] rdata_q,
   output logic [15:0] count_q,
   output logic overflow_flag_q,
   output logic irq_q,
   output logic adc_start_q,
   output logic osc_enable_q
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [2:0] ps_last(input logic [1:0] sel);
      logic [2:0] r;
      r = `STC_PS_LAST_1;
      case (sel)
         `STC_PS_1: r = `STC_PS_LAST_1;
         `STC_PS_2: r = `STC_PS_LAST_2;
         `STC_PS_4: r = `STC_PS_LAST_4;
         default: r = `STC_PS_LAST_8;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // External clock synchroniser
   // ----------------------------------------
   logic ext_s1_q, ext_s2_q, ext_s3_q;
   logic ext_edge;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= ext_clk_pin;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // Rising edge seen after the second flop only
   assign ext_edge = ext_s2_q & ~ext_s3_q;

   // ----------------------------------------
   // Clock source, prescaler
   // ----------------------------------------
   logic [1:0] div_q, div_d;
   logic [2:0] ps_q, ps_d;
   logic inst_tick, src_tick, cnt_tick;

   always_comb begin
      div_d = div_q + 2'h1;
      inst_tick = (div_q == `STC_FOSC_DIV_LAST);
      // Sync bypass has no effect here: one clock means sampling anyway [RQ19]
      src_tick = ctrl.clock_source_select ? ext_edge : inst_tick; // [RQ16] [RQ19]
      ps_d = ps_q;
      cnt_tick = 1'b0;
      if (ctrl.timer_run && src_tick) begin // [RQ18]
         if (ps_q == ps_last(ctrl.prescale_select)) begin // [RQ17]
            ps_d = 3'h0;
            cnt_tick = 1'b1;
         end else begin
            ps_d = ps_q + 3'h1;
         end
      end
      if (acc.lo_wr) begin
         ps_d = 3'h0; // [RQ13]
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         div_q <= 2'h0;
         ps_q <= 3'h0;
      end else begin
         div_q <= div_d;
         ps_q <= ps_d;
      end
   end

   // ----------------------------------------
   // Counter, buffer, flag
   // ----------------------------------------
   logic [15:0] count_d;
   logic [7:0] hbuf_q, hbuf_d, rdata_d;
   logic flag_d, irq_d, adc_d, trig, ovf, wr_any;
   logic wide;

   assign wide = ctrl.wide_access_enable;

   always_comb begin
      // Match against period gives the special event trigger
      trig = (compare_mode_select == `STC_SPECIAL_MODE) &&
             (count_q == compare_value_pair); // [RQ4] [RQ8]
      wr_any = acc.lo_wr | (acc.hi_wr & ~wide);
      count_d = count_q;
      if (acc.lo_wr) begin
         // Whole word lands at once in wide mode
         count_d = {(wide ? hbuf_q : count_q[15:8]), acc.wdata}; // [RQ11] [RQ7]
      end else if (acc.hi_wr && !wide) begin
         count_d = {acc.wdata, count_q[7:0]}; // [RQ12] [RQ7]
      end else if (trig) begin
         count_d = `STC_CNT_RST; // [RQ4]
      end else if (cnt_tick) begin
         count_d = count_q + 16'h0001; // [RQ1]
      end
      ovf = cnt_tick && (count_q == `STC_CNT_ALL1) && !trig && !wr_any; // [RQ5]
      // Set beats clear so a wrap in the clear cycle survives
      if (ovf) begin
         flag_d = 1'b1; // [RQ2] [RQ20]
      end else if (acc.flag_clr) begin
         flag_d = 1'b0;
      end else begin
         flag_d = overflow_flag_q; // [RQ20]
      end
      irq_d = flag_d & overflow_irq_enable; // [RQ3]
      adc_d = trig & adc_enable; // [RQ4]
      hbuf_d = hbuf_q;
      if (wide && acc.hi_wr) begin
         hbuf_d = acc.wdata; // [RQ9]
      end else if (wide && acc.lo_rd) begin
         hbuf_d = count_q[15:8]; // [RQ10]
      end
      rdata_d = rdata_q;
      if (acc.lo_rd) begin
         rdata_d = count_q[7:0];
      end else if (acc.hi_rd) begin
         rdata_d = wide ? hbuf_q : count_q[15:8]; // [RQ9] [RQ12]
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         count_q <= `STC_CNT_RST;
         hbuf_q <= 8'h00;
         rdata_q <= 8'h00;
         overflow_flag_q <= 1'b0;
         irq_q <= 1'b0;
         adc_start_q <= 1'b0;
         osc_enable_q <= 1'b0;
      end else begin
         count_q <= count_d;
         hbuf_q <= hbuf_d;
         rdata_q <= rdata_d;
         overflow_flag_q <= flag_d;
         irq_q <= irq_d;
         adc_start_q <= adc_d;
         osc_enable_q <= ctrl.crystal_osc_enable;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Spacing of 1:8 ticks; a config change or low write disarms it
   logic [5:0] gap_q, gap_d;
   logic slow_cfg, gap_arm_q, gap_arm_d;

   always_comb begin
      slow_cfg = ctrl.timer_run && !ctrl.clock_source_select &&
                 (ctrl.prescale_select == `STC_PS_8);
      gap_d = gap_q;
      gap_arm_d = gap_arm_q;
      if (cnt_tick) begin
         gap_d = 6'h00;
         gap_arm_d = slow_cfg;
      end else begin
         if (gap_q != 6'h3f) begin
            gap_d = gap_q + 6'h01;
         end
         if (!slow_cfg || acc.lo_wr) begin
            gap_arm_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         gap_q <= 6'h00;
         gap_arm_q <= 1'b0;
      end else begin
         gap_q <= gap_d;
         gap_arm_q <= gap_arm_d;
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------

   sequence s_wide_lo_rd;
      wide && acc.lo_rd && !acc.hi_wr;
   endsequence

   sequence s_quiet_hi_rd;
      wide && acc.hi_rd && !acc.hi_wr && !acc.lo_rd;
   endsequence

   sequence s_wrap;
      cnt_tick && count_q == 16'hffff && !trig && !wr_any;
   endsequence

   sequence s_plain_tick;
      cnt_tick && !trig && !acc.lo_wr && !(acc.hi_wr && !wide);
   endsequence

   wrap_sets_flag_a: assert property (s_wrap |=> overflow_flag_q && count_q == 16'h0000) // [RQ2]
      else $error("wrap did not set flag");
   trig_no_flag_a: assert property (trig && !wr_any && !overflow_flag_q // [RQ5]
      |=> count_q == 16'h0000 && !overflow_flag_q)
      else $error("trigger clear touched flag");
   write_wins_a: assert property (trig && acc.lo_wr && !wide // [RQ7]
      |=> count_q == {$past(count_q[15:8]), $past(acc.wdata)})
      else $error("trigger beat write");
   snap_read_a: assert property (s_wide_lo_rd ##1 s_quiet_hi_rd // [RQ10]
      |=> rdata_q == $past(count_q[15:8], 2))
      else $error("high snapshot wrong");
   lo_write_load_a: assert property (wide && acc.lo_wr // [RQ11]
      |=> count_q == {$past(hbuf_q), $past(acc.wdata)})
      else $error("wide write not atomic");
   hi_hidden_a: assert property (wide && acc.hi_wr && !acc.lo_wr && !trig && !cnt_tick // [RQ12]
      |=> count_q == $past(count_q) && hbuf_q == $past(acc.wdata))
      else $error("wide high write reached counter");
   ps_clear_a: assert property (acc.lo_wr |=> ps_q == 3'h0) // [RQ13]
      else $error("prescaler not cleared");
   hi_keeps_ps_a: assert property (acc.hi_wr && !acc.lo_wr && !src_tick // [RQ13]
      |=> ps_q == $past(ps_q))
      else $error("high write moved prescaler");
   irq_gate_a: assert property (irq_q |-> $past(overflow_irq_enable)) // [RQ3]
      else $error("irq without enable");
   flag_sticky_a: assert property (overflow_flag_q && !acc.flag_clr |=> overflow_flag_q) // [RQ20]
      else $error("flag dropped");
   stop_hold_a: assert property (!ctrl.timer_run && !acc.lo_wr && !acc.hi_wr && !trig // [RQ18]
      |=> count_q == $past(count_q))
      else $error("counter moved while stopped");
   inst_rate_a: assert property (cnt_tick && slow_cfg && gap_arm_q // [RQ16] [RQ17]
      |-> gap_q == 6'h1f)
      else $error("slow prescale spacing wrong");
   inst_div_a: assert property (inst_tick |=> (!inst_tick) [*3] ##1 inst_tick) // [RQ16]
      else $error("instruction tick not every fourth clock");
   count_step_a: assert property (s_plain_tick // [RQ1]
      |=> count_q == $past(count_q) + 16'h0001)
      else $error("count step wrong");
   ext_step_a: assert property (ctrl.timer_run && ctrl.clock_source_select && ext_edge // [RQ19]
      && ctrl.prescale_select == 2'h0 && ps_q == 3'h0 && !trig && !wr_any
      |=> count_q == $past(count_q) + 16'h0001)
      else $error("external edge not counted");
   lo_read_a: assert property (acc.lo_rd |=> rdata_q == $past(count_q[7:0])) // [RQ10]
      else $error("low read wrong");
   hi_live_a: assert property (!wide && acc.hi_rd && !acc.lo_rd // [RQ9]
      |=> rdata_q == $past(count_q[15:8]))
      else $error("live high read wrong");
   hi_buf_read_a: assert property (wide && acc.hi_rd && !acc.lo_rd // [RQ12]
      |=> rdata_q == $past(hbuf_q))
      else $error("buffer high read wrong");
   adc_fire_a: assert property (trig && adc_enable |=> adc_start_q) // [RQ4]
      else $error("conversion start missing");
   adc_gate_a: assert property (adc_start_q |-> $past(adc_enable)) // [RQ4]
      else $error("conversion start without enable");
   irq_follow_a: assert property (overflow_flag_q && overflow_irq_enable && !acc.flag_clr // [RQ3]
      |=> irq_q)
      else $error("irq missing");

endmodule // stc_timer

// >>> verif/stc_timer_tb.sv
// Purpose: Self-checking bench for the sixteen bit timer counter
// Assumes: Inputs change 2 ns after the rising edge
// Notes: Internal tick phase is free running, so rates are timed edge to edge
`timescale 1ns/10ps
module stc_timer_tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   stc_pkg::stc_ctrl_t ctrl = '0;
   stc_pkg::stc_acc_t acc = '0;
   logic irq_en = 1'b0;
   logic [3:0] mode = 4'h0;
   logic [15:0] period = 16'h0005;
   logic adc_en = 1'b1;
   logic pin = 1'b0;
   logic [7:0] rdata;
   logic [15:0] cnt;
   logic [15:0] c;
   logic flag, irq, adc_st, osc;
   int fail_count = 0;
   int compares = 0;
   int n;
   stc_timer dut (.clk(clk), .rstn(rstn), .ctrl(ctrl), .acc(acc),
      .overflow_irq_enable(irq_en), .compare_mode_select(mode),
      .compare_value_pair(period), .adc_enable(adc_en), .ext_clk_pin(pin),
      .rdata_q(rdata), .count_q(cnt), .overflow_flag_q(flag), .irq_q(irq),
      .adc_start_q(adc_st), .osc_enable_q(osc));
   always #10 clk = ~clk;
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Strobes lo_rd, lo_wr, hi_rd, hi_wr, flag_clr; idle cycle after each
   task automatic op(input logic [4:0] s, input logic [7:0] d);
      acc = {s, d};
      step(1);
      acc = '0;
      step(1);
   endtask
   task automatic conclude;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Chg set: wait while count equals v; clear: wait until it does
   task automatic waitc(input logic chg, input logic [15:0] v);
      n = 0;
      while (((cnt === v) == chg) && n < 2000) begin
         step(1);
         n++;
      end
      if (n == 2000) begin
         fail_count++;
         $display("unexpected at %0t: wait timed out", $time);
         conclude();
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      step(3);
      rstn = 1'b1;
      step(1);
      chk(cnt, 16'h0000);
      chk(osc, 1'b0);
      op(5'h02, 8'hff);
      op(5'h08, 8'hfd);
      chk(cnt, 16'hfffd);
      ctrl.timer_run = 1'b1;
      waitc(1'b0, 16'h0000);
      chk(flag, 1'b1);
      chk(irq, 1'b0);
      step(12);
      chk(flag, 1'b1);
      irq_en = 1'b1;
      step(1);
      chk(irq, 1'b1);
      op(5'h01, 8'h00);
      chk(flag, 1'b0);
      chk(irq, 1'b0);
      // Timekeeping preset: top bit of high byte only, low byte untouched
      op(5'h02, 8'h80);
      chk(cnt[15:8], 8'h80);
      // Two syncs first: a code change may cut the running division short
      for (int i = 0; i < 4; i++) begin
         ctrl.prescale_select = i[1:0];
         waitc(1'b1, cnt);
         waitc(1'b1, cnt);
         waitc(1'b1, cnt);
         chk(n[15:0], 16'h4 << i);
      end
      ctrl.timer_run = 1'b0;
      step(2);
      c = cnt;
      step(40);
      chk(cnt, c);
      ctrl.wide_access_enable = 1'b1;
      op(5'h02, 8'h12);
      chk(cnt, c);
      op(5'h08, 8'h34);
      chk(cnt, 16'h1234);
      op(5'h02, 8'h56);
      op(5'h04, 8'h00);
      chk(rdata, 8'h56);
      chk(cnt, 16'h1234);
      op(5'h10, 8'h00);
      chk(rdata, 8'h34);
      op(5'h04, 8'h00);
      chk(rdata, 8'h12);
      // Back to back: low read snapshot must replace the buffered byte
      op(5'h02, 8'h77);
      acc = {5'h10, 8'h00};
      step(1);
      chk(rdata, 8'h34);
      acc = {5'h04, 8'h00};
      step(1);
      acc = '0;
      chk(rdata, 8'h12);
      step(1);
      ctrl.wide_access_enable = 1'b0;
      ctrl.prescale_select = 2'h0;
      mode = 4'hb;
      op(5'h02, 8'h00);
      op(5'h08, 8'h00);
      ctrl.timer_run = 1'b1;
      for (int j = 0; j < 2; j++) begin
         adc_en = ~j[0];
         waitc(1'b0, 16'h0005);
         step(1);
         chk(cnt, 16'h0000);
         chk(adc_st, {15'h0, ~j[0]});
         chk(flag, 1'b0);
         step(1);
         chk(adc_st, 1'b0);
      end
      ctrl.timer_run = 1'b0;
      mode = 4'h0;
      op(5'h08, 8'h05);
      mode = 4'hb;
      op(5'h08, 8'h09);
      chk(cnt, 16'h0009);
      op(5'h04, 8'h00);
      chk(rdata, 8'h00);
      mode = 4'h0;
      ctrl.clock_source_select = 1'b1;
      ctrl.crystal_osc_enable = 1'b1;
      ctrl.timer_run = 1'b1;
      for (int j = 0; j < 2; j++) begin
         ctrl.ext_clock_sync_bypass = j[0];
         repeat (3) begin
            pin = 1'b1;
            step(4);
            pin = 1'b0;
            step(4);
         end
      end
      chk(cnt, 16'h000f);
      chk(osc, 1'b1);
      conclude();
   end
endmodule // stc_timer_tb
